// ### design/lsgtf_hyst_expand.sv
`timescale 1ns/1ps
// expands an 8-bit compressed code (4-bit exponent, 4-bit mantissa) to 16 bits
module lsgtf_hyst_expand (
   input wire logic [7:0] code, // compressed code
   output logic [15:0] value // expanded value
);

   logic [35:0] wide;

   always_comb begin
      wide = {31'h0, 1'b1, code[3:0]} << code[7:4];
      value = wide[19:4];
   end

endmodule

// ### design/lsgtf_persist_filter.sv
`timescale 1ns/1ps
module lsgtf_persist_filter #(
   parameter bit INVERT = 1'b0 // 1: idle state tests for a fall below the threshold
) (
   input wire logic pclk, // clock
   input wire logic presetn, // async reset, active low
   input wire logic sample_valid, // one-cycle sample strobe
   input wire logic [15:0] sample, // sample value
   input wire logic [15:0] threshold, // threshold
   input wire logic [15:0] hyst, // expanded hysteresis
   input wire logic [7:0] mask, // persistence mask
   output logic status, // filtered crossing status
   output logic changed // pulse in the cycle the status changes
);

   typedef struct packed {
      logic status;
      logic changed;
      logic [3:0] run;
   } lsgtf_flt_type;

   lsgtf_flt_type s_q, s_d;
   logic [16:0] up_sum;
   logic [15:0] up_lim;
   logic [15:0] dn_lim;
   logic rising_test;
   logic hit;
   logic [3:0] need;

   always_comb begin
      up_sum = {1'b0, threshold} + {1'b0, hyst};
      up_lim = up_sum[16] ? 16'hffff : up_sum[15:0];
      dn_lim = (threshold > hyst) ? 16'(threshold - hyst) : 16'h0000;
      rising_test = (s_q.status ^ INVERT) == 1'b0;
      hit = rising_test ? (sample > up_lim) : (sample < dn_lim); // R9
      need = lsgtf_pkg::ones_count(mask); // R6 R7
      if (need == 4'h0) begin
         need = 4'h1;
      end
      s_d = s_q;
      s_d.changed = 1'b0;
      if (sample_valid) begin
         if (!hit) begin
            s_d.run = lsgtf_pkg::RUN_RST; // R9
         end else if (4'(s_q.run + 4'h1) >= need) begin
            s_d.status = ~s_q.status; // R6 R7
            s_d.changed = 1'b1;
            s_d.run = lsgtf_pkg::RUN_RST;
         end else begin
            s_d.run = 4'(s_q.run + 4'h1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign status = s_q.status;
   assign changed = s_q.changed;

   // ****************************************
   // assertions
   // ****************************************
   property p_change_needs_sample;
      @(posedge pclk) disable iff (!presetn) $changed(status) |-> $past(sample_valid) && $past(hit);
   endproperty
   a_change_needs_sample: assert property (p_change_needs_sample) else $error("status moved without a hit"); // R6

   property p_run_restart;
      @(posedge pclk) disable iff (!presetn) (sample_valid && !hit) |=> (s_q.run == 4'h0) && $stable(status);
   endproperty
   a_run_restart: assert property (p_run_restart) else $error("run not restarted on a miss"); // R9

   property p_changed_pulse;
      @(posedge pclk) disable iff (!presetn) $changed(status) |-> changed ##1 !changed || $changed(status);
   endproperty
   a_changed_pulse: assert property (p_changed_pulse) else $error("change pulse wrong"); // R7

   c_status_flip: cover property (@(posedge pclk) disable iff (!presetn) changed);

endmodule

// ### design/lsgtf_pkg.sv
package lsgtf_pkg;

   // ****************************************
   // register indices (byte address is four times the index)
   // ****************************************
   localparam logic [7:0] IDX_VIS_GAIN = 8'h11;
   localparam logic [7:0] IDX_VIS_MISC = 8'h12;
   localparam logic [7:0] IDX_AMB_HYST = 8'h16;
   localparam logic [7:0] IDX_PRX_HYST = 8'h17;
   localparam logic [7:0] IDX_PS_PERSIST = 8'h18;
   localparam logic [7:0] IDX_ALS_PERSIST = 8'h19;
   localparam logic [7:0] IDX_AMB_LOW_TH = 8'h20;
   localparam logic [7:0] IDX_AMB_HIGH_TH = 8'h21;
   localparam logic [7:0] IDX_PS_TH0 = 8'h22;
   localparam logic [7:0] IDX_PS_TH1 = 8'h23;
   localparam logic [7:0] IDX_PS_TH2 = 8'h24;
   localparam logic [7:0] IDX_IR_CFG = 8'h25;
   localparam logic [7:0] IDX_SEQ_CFG = 8'h26;
   localparam logic [7:0] IDX_FLT_STATUS = 8'h27;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h28;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h29;

   // ****************************************
   // field positions
   // ****************************************
   localparam int GAIN_MSB = 2;
   localparam int RANGE_BIT = 5;
   localparam int EARLY_REV_BIT = 0;
   localparam int NUM_EVENTS = 5;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [2:0] RST_GAIN = 3'h0;
   localparam logic RST_RANGE = 1'b0;
   localparam logic [7:0] RST_HYST = 8'h48;
   localparam logic [7:0] RST_PERSIST = 8'h03;
   localparam logic [15:0] RST_THRESHOLD = 16'hffff;
   localparam logic RST_EARLY_REV = 1'b0;
   localparam logic [4:0] RST_IRQ = 5'h00;

   // ****************************************
   // counts
   // ****************************************
   localparam logic [6:0] DIV_CNT_RST = 7'h00;
   localparam logic [3:0] RUN_RST = 4'h0;
   localparam logic [7:0] TICK_GAP_MAX = 8'h7f;

   function automatic logic [7:0] reg_index(input logic [11:0] addr);
      reg_index = addr[9:2];
   endfunction

   function automatic logic [3:0] ones_count(input logic [7:0] m);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 8; i++) begin
         n = n + {3'h0, m[i]};
      end
      ones_count = n;
   endfunction

endpackage

// ### design/lsgtf_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: the visible integration is lengthened by 2 to the 3-bit gain exponent, dividing the adc clock (7 gives 128).
// R2: bit 5 of the visible misc setting selects the high signal range, with gain reduced by 14.5.
// R3: on early sequencer revisions the visible gain and range also govern infrared ambient measurements.
// R4: one ambient hysteresis, a compressed 8-bit code for 16 bits, applies to both ambient thresholds.
// R5: one proximity hysteresis, coded the same way, applies to all three proximity thresholds.
// R6: a proximity status changes only after as many consecutive crossings as its mask has set bits.
// R7: an ambient status changes only after as many consecutive crossings as its mask has set bits.
// R8: the host should set the visible recovery period to the one's complement of the gain exponent.
// R9: rising crossings test threshold plus hysteresis, falling ones minus it; a miss restarts the count.
module lsgtf_top (
   input wire logic pclk, // clock, 100 MHz
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic als_valid, // ambient sample strobe
   input wire logic [15:0] als_sample, // ambient sample
   input wire logic ps_valid, // proximity sample strobe
   input wire logic [1:0] ps_channel, // proximity channel 0..2
   input wire logic [15:0] ps_sample, // proximity sample
   output logic vis_adc_tick, // divided visible adc clock tick
   output logic [2:0] visible_gain_exponent, // visible gain exponent
   output logic visible_signal_range, // visible high range
   output logic [2:0] ir_gain_exponent, // effective infrared gain
   output logic ir_signal_range, // effective infrared range
   output logic als_low_status, // ambient below low threshold
   output logic als_high_status, // ambient above high threshold
   output logic [2:0] ps_status, // proximity above thresholds
   output logic irq // interrupt, level
);

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [2:0] vis_gain;
      logic vis_rng;
      logic [7:0] amb_hyst;
      logic [7:0] prx_hyst;
      logic [7:0] ps_mask;
      logic [7:0] als_mask;
      logic [15:0] als_lo;
      logic [15:0] als_hi;
      logic [2:0][15:0] ps_th;
      logic [2:0] ir_gain;
      logic ir_range;
      logic early_rev;
      logic [4:0] irq_stat;
      logic [4:0] irq_mask;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [6:0] div_cnt;
      logic tick;
      logic [2:0] eff_ir_gain;
      logic eff_ir_range;
      logic [7:0] chk_gap;
      logic chk_run7;
   } lsgtf_regs_type;

   lsgtf_regs_type s_q, s_d;

   logic [7:0] idx;
   logic access;
   logic wr_en;
   logic mapped;
   logic [31:0] rd_val;
   logic [7:0] lim8;
   logic [6:0] div_lim;
   logic [15:0] amb_hyst_val;
   logic [15:0] prx_hyst_val;
   logic [4:0] events;
   logic [4:0] w1c;
   logic als_lo_chg;
   logic als_hi_chg;
   logic [2:0] ps_chg;

   // ****************************************
   // hysteresis expansion
   // ****************************************
   lsgtf_hyst_expand u_amb_hyst ( // R4
      .code(s_q.amb_hyst),
      .value(amb_hyst_val)
   );

   lsgtf_hyst_expand u_prx_hyst ( // R5
      .code(s_q.prx_hyst),
      .value(prx_hyst_val)
   );

   // ****************************************
   // persistence filters
   // ****************************************
   lsgtf_persist_filter #(
      .INVERT(1'b1)
   ) u_als_low (
      .pclk(pclk),
      .presetn(presetn),
      .sample_valid(als_valid),
      .sample(als_sample),
      .threshold(s_q.als_lo),
      .hyst(amb_hyst_val), // R4
      .mask(s_q.als_mask), // R7
      .status(als_low_status),
      .changed(als_lo_chg)
   );

   lsgtf_persist_filter #(
      .INVERT(1'b0)
   ) u_als_high (
      .pclk(pclk),
      .presetn(presetn),
      .sample_valid(als_valid),
      .sample(als_sample),
      .threshold(s_q.als_hi),
      .hyst(amb_hyst_val), // R4
      .mask(s_q.als_mask), // R7
      .status(als_high_status),
      .changed(als_hi_chg)
   );

   generate
      for (genvar g = 0; g < 3; g++) begin : g_ps
         lsgtf_persist_filter #(
            .INVERT(1'b0)
         ) u_ps (
            .pclk(pclk),
            .presetn(presetn),
            .sample_valid(ps_valid && (ps_channel == 2'(g))),
            .sample(ps_sample),
            .threshold(s_q.ps_th[g]),
            .hyst(prx_hyst_val), // R5
            .mask(s_q.ps_mask), // R6
            .status(ps_status[g]),
            .changed(ps_chg[g])
         );
      end
   endgenerate

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      idx = lsgtf_pkg::reg_index(paddr);
      access = psel && penable;
      wr_en = access && pwrite && s_q.pready;
      events = {ps_chg, als_hi_chg, als_lo_chg};
      w1c = 5'h00;
      mapped = 1'b1;
      rd_val = 32'h0000_0000;
      unique case (idx)
         lsgtf_pkg::IDX_VIS_GAIN: rd_val = {29'h0, s_q.vis_gain};
         lsgtf_pkg::IDX_VIS_MISC: rd_val = {26'h0, s_q.vis_rng, 5'h00};
         lsgtf_pkg::IDX_AMB_HYST: rd_val = {24'h0, s_q.amb_hyst};
         lsgtf_pkg::IDX_PRX_HYST: rd_val = {24'h0, s_q.prx_hyst};
         lsgtf_pkg::IDX_PS_PERSIST: rd_val = {24'h0, s_q.ps_mask};
         lsgtf_pkg::IDX_ALS_PERSIST: rd_val = {24'h0, s_q.als_mask};
         lsgtf_pkg::IDX_AMB_LOW_TH: rd_val = {16'h0, s_q.als_lo};
         lsgtf_pkg::IDX_AMB_HIGH_TH: rd_val = {16'h0, s_q.als_hi};
         lsgtf_pkg::IDX_PS_TH0: rd_val = {16'h0, s_q.ps_th[0]};
         lsgtf_pkg::IDX_PS_TH1: rd_val = {16'h0, s_q.ps_th[1]};
         lsgtf_pkg::IDX_PS_TH2: rd_val = {16'h0, s_q.ps_th[2]};
         lsgtf_pkg::IDX_IR_CFG: rd_val = {26'h0, s_q.ir_range, 2'h0, s_q.ir_gain};
         lsgtf_pkg::IDX_SEQ_CFG: rd_val = {31'h0, s_q.early_rev};
         lsgtf_pkg::IDX_FLT_STATUS: rd_val = {27'h0, ps_status, als_high_status, als_low_status};
         lsgtf_pkg::IDX_IRQ_STATUS: rd_val = {27'h0, s_q.irq_stat};
         lsgtf_pkg::IDX_IRQ_MASK: rd_val = {27'h0, s_q.irq_mask};
         default: mapped = 1'b0;
      endcase
      if (paddr[11:10] != 2'h0 || paddr[1:0] != 2'h0) begin
         mapped = 1'b0;
      end

      s_d = s_q;

      // apb: ready comes in the second access cycle
      s_d.pready = access && !s_q.pready;
      s_d.pslverr = access && !s_q.pready && !mapped;
      s_d.prdata = (access && !s_q.pready && !pwrite && mapped) ? rd_val : 32'h0000_0000;

      if (wr_en && mapped) begin
         unique case (idx)
            lsgtf_pkg::IDX_VIS_GAIN: s_d.vis_gain = pwdata[lsgtf_pkg::GAIN_MSB:0]; // R1
            lsgtf_pkg::IDX_VIS_MISC: s_d.vis_rng = pwdata[lsgtf_pkg::RANGE_BIT]; // R2
            lsgtf_pkg::IDX_AMB_HYST: s_d.amb_hyst = pwdata[7:0]; // R4
            lsgtf_pkg::IDX_PRX_HYST: s_d.prx_hyst = pwdata[7:0]; // R5
            lsgtf_pkg::IDX_PS_PERSIST: s_d.ps_mask = pwdata[7:0]; // R6
            lsgtf_pkg::IDX_ALS_PERSIST: s_d.als_mask = pwdata[7:0]; // R7
            lsgtf_pkg::IDX_AMB_LOW_TH: s_d.als_lo = pwdata[15:0];
            lsgtf_pkg::IDX_AMB_HIGH_TH: s_d.als_hi = pwdata[15:0];
            lsgtf_pkg::IDX_PS_TH0: s_d.ps_th[0] = pwdata[15:0];
            lsgtf_pkg::IDX_PS_TH1: s_d.ps_th[1] = pwdata[15:0];
            lsgtf_pkg::IDX_PS_TH2: s_d.ps_th[2] = pwdata[15:0];
            lsgtf_pkg::IDX_IR_CFG: begin
               s_d.ir_gain = pwdata[lsgtf_pkg::GAIN_MSB:0];
               s_d.ir_range = pwdata[lsgtf_pkg::RANGE_BIT];
            end
            lsgtf_pkg::IDX_SEQ_CFG: s_d.early_rev = pwdata[lsgtf_pkg::EARLY_REV_BIT];
            lsgtf_pkg::IDX_IRQ_STATUS: w1c = pwdata[4:0];
            lsgtf_pkg::IDX_IRQ_MASK: s_d.irq_mask = pwdata[4:0];
            default: ;
         endcase
      end

      // sticky events: a new event wins over a clear in the same cycle
      s_d.irq_stat = (s_q.irq_stat & ~w1c) | events;
      s_d.irq = |(s_q.irq_stat & s_q.irq_mask);

      // adc clock divider: one tick every 2^gain cycles
      lim8 = 8'(8'h01 << s_q.vis_gain) - 8'h01;
      div_lim = lim8[6:0];
      if (s_q.div_cnt >= div_lim) begin // R1
         s_d.div_cnt = lsgtf_pkg::DIV_CNT_RST;
         s_d.tick = 1'b1;
      end else begin
         s_d.div_cnt = 7'(s_q.div_cnt + 7'h01);
         s_d.tick = 1'b0;
      end

      // infrared settings: early revisions reuse the visible ones
      s_d.eff_ir_gain = s_q.early_rev ? s_q.vis_gain : s_q.ir_gain; // R3
      s_d.eff_ir_range = s_q.early_rev ? s_q.vis_rng : s_q.ir_range; // R3

      // assertion helper: cycles since the last tick, and whether the gain stayed at 7 over them
      s_d.chk_gap = s_q.tick ? 8'h00 : ((s_q.chk_gap == 8'hff) ? 8'hff : 8'(s_q.chk_gap + 8'h01));
      s_d.chk_run7 = (s_q.tick || s_q.chk_run7) && (s_q.vis_gain == 3'h7);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.vis_gain <= lsgtf_pkg::RST_GAIN;
         s_q.vis_rng <= lsgtf_pkg::RST_RANGE;
         s_q.amb_hyst <= lsgtf_pkg::RST_HYST;
         s_q.prx_hyst <= lsgtf_pkg::RST_HYST;
         s_q.ps_mask <= lsgtf_pkg::RST_PERSIST;
         s_q.als_mask <= lsgtf_pkg::RST_PERSIST;
         s_q.als_lo <= 16'h0000;
         s_q.als_hi <= lsgtf_pkg::RST_THRESHOLD;
         s_q.ps_th <= {3{lsgtf_pkg::RST_THRESHOLD}};
         s_q.early_rev <= lsgtf_pkg::RST_EARLY_REV;
         s_q.irq_stat <= lsgtf_pkg::RST_IRQ;
         s_q.irq_mask <= lsgtf_pkg::RST_IRQ;
         s_q.div_cnt <= lsgtf_pkg::DIV_CNT_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign vis_adc_tick = s_q.tick;
   assign visible_gain_exponent = s_q.vis_gain;
   assign visible_signal_range = s_q.vis_rng;
   assign ir_gain_exponent = s_q.eff_ir_gain;
   assign ir_signal_range = s_q.eff_ir_range;
   assign irq = s_q.irq;

   // ****************************************
   // assertions
   // ****************************************
   property p_gain_write;
      @(posedge pclk) disable iff (!presetn)
         (wr_en && mapped && idx == lsgtf_pkg::IDX_VIS_GAIN) |=> visible_gain_exponent == $past(pwdata[2:0]);
   endproperty
   a_gain_write: assert property (p_gain_write) else $error("gain write lost"); // R1

   property p_tick_gap;
      @(posedge pclk) disable iff (!presetn) (vis_adc_tick && visible_gain_exponent != 3'h0) |=> !vis_adc_tick;
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("adc tick not divided"); // R1

   property p_tick_max;
      @(posedge pclk) disable iff (!presetn)
         s_q.chk_run7 |-> vis_adc_tick == (s_q.chk_gap == lsgtf_pkg::TICK_GAP_MAX);
   endproperty
   a_tick_max: assert property (p_tick_max) else $error("divide by 128 wrong"); // R1

   property p_range_write;
      @(posedge pclk) disable iff (!presetn)
         (wr_en && mapped && idx == lsgtf_pkg::IDX_VIS_MISC) |=> visible_signal_range == $past(pwdata[5]);
   endproperty
   a_range_write: assert property (p_range_write) else $error("range write lost"); // R2

   property p_ir_follows;
      @(posedge pclk) disable iff (!presetn)
         s_q.early_rev |=> ir_gain_exponent == $past(visible_gain_exponent) && ir_signal_range == $past(visible_signal_range);
   endproperty
   a_ir_follows: assert property (p_ir_follows) else $error("infrared not following visible"); // R3

   property p_amb_hyst;
      @(posedge pclk) disable iff (!presetn) s_q.amb_hyst == 8'h48 |-> amb_hyst_val == 16'h0018;
   endproperty
   a_amb_hyst: assert property (p_amb_hyst) else $error("ambient hysteresis decode wrong"); // R4

   property p_prx_hyst;
      @(posedge pclk) disable iff (!presetn) s_q.prx_hyst == 8'h48 |-> prx_hyst_val == 16'h0018;
   endproperty
   a_prx_hyst: assert property (p_prx_hyst) else $error("proximity hysteresis decode wrong"); // R5

   property p_irq_level;
      @(posedge pclk) disable iff (!presetn) (|(s_q.irq_stat & s_q.irq_mask)) |=> irq;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

   property p_ready_once;
      @(posedge pclk) disable iff (!presetn) (psel && penable && !pready) |=> pready ##1 !pready;
   endproperty
   a_ready_once: assert property (p_ready_once) else $error("apb ready timing wrong");

   property p_err_with_ready;
      @(posedge pclk) disable iff (!presetn) pslverr |-> pready;
   endproperty
   a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");

   property p_rdata_idle;
      @(posedge pclk) disable iff (!presetn) !pready |-> prdata == 32'h0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside transfer");

   property p_set_wins;
      @(posedge pclk) disable iff (!presetn) (|events) |=> (s_q.irq_stat & $past(events)) == $past(events);
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost in status");

   property p_w1c;
      @(posedge pclk) disable iff (!presetn) (wr_en && mapped && idx == lsgtf_pkg::IDX_IRQ_STATUS && events == 5'h00)
         |=> (s_q.irq_stat & $past(pwdata[4:0])) == 5'h00;
   endproperty
   a_w1c: assert property (p_w1c) else $error("status bit not cleared");

   c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
   c_err: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
   c_ps_change: cover property (@(posedge pclk) disable iff (!presetn) |ps_chg);
   c_tick_max: cover property (@(posedge pclk) disable iff (!presetn) s_q.chk_run7 && vis_adc_tick);

endmodule

// ### sim/lsgtf_host_model.sv
`timescale 1ns/1ps
module lsgtf_host_model (
   input wire logic pclk, // clock
   input wire logic pready, // apb ready
   output logic psel, // apb select
   output logic penable, // apb enable
   output logic pwrite, // apb direction
   output logic [11:0] paddr, // apb byte address
   output logic [31:0] pwdata // apb write data
);
   bit to_flag;
   initial begin
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      to_flag = 1'h0;
   end
   // recovery period that the host pairs with a gain exponent
   function automatic logic [2:0] recovery_for(input logic [2:0] gain);
      recovery_for = ~gain;
   endfunction
   // ****************************************
   // one transfer, request held until pready is sampled high
   // ****************************************
   task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      n = 1;
      while (pready !== 1'h1 && n < 50) begin
         @(posedge pclk);
         n++;
      end
      if (pready !== 1'h1) to_flag = 1'h1;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
endmodule

// ### sim/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, als_valid, ps_valid, vis_adc_tick;
   logic visible_signal_range, ir_signal_range, als_low_status, als_high_status, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [15:0] als_sample, ps_sample;
   logic [1:0] ps_channel;
   logic [2:0] visible_gain_exponent, ir_gain_exponent, ps_status;
   int err_count, n_compared, gap;
   integer seed;
   logic [32:0] exp_q[$];

   lsgtf_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .als_valid(als_valid), .als_sample(als_sample), .ps_valid(ps_valid), .ps_channel(ps_channel),
      .ps_sample(ps_sample), .vis_adc_tick(vis_adc_tick), .visible_gain_exponent(visible_gain_exponent),
      .visible_signal_range(visible_signal_range), .ir_gain_exponent(ir_gain_exponent),
      .ir_signal_range(ir_signal_range), .als_low_status(als_low_status), .als_high_status(als_high_status),
      .ps_status(ps_status), .irq(irq));
   lsgtf_host_model host (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata));

   initial pclk = 1'h0;
   always #5 pclk = ~pclk;

   // ****************************************
   // comparison, report and closing
   // ****************************************
   task automatic chk(input logic [32:0] seen, input logic [32:0] expv);
      n_compared++;
      if (seen !== expv) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
      end
   endtask
   task automatic stop_test();
      if (host.to_flag) err_count++;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // oldest noted answer is compared when a transfer completes
   always @(posedge pclk) begin
      if (psel === 1'h1 && penable === 1'h1 && pready === 1'h1) begin
         chk({pslverr, prdata}, (exp_q.size() > 0) ? exp_q.pop_front() : 33'hx);
      end
   end

   // ****************************************
   // bus and sample drivers
   // ****************************************
   task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [32:0] e);
      exp_q.push_back(e);
      host.xfer(a, w, d);
      if (host.to_flag) begin
         stop_test();
      end else begin
         // let registered outputs that follow the write settle
         repeat (2) @(posedge pclk);
         #1;
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      bus({2'h0, idx, 2'h0}, 1'h1, d, 33'h0);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [31:0] e);
      bus({2'h0, idx, 2'h0}, 1'h0, 32'h0, {1'h0, e});
   endtask
   task automatic smp(input logic is_ps, input logic [1:0] ch, input logic [15:0] v, input int n);
      repeat (n) begin
         @(posedge pclk);
         als_valid <= ~is_ps;
         ps_valid <= is_ps;
         ps_channel <= ch;
         als_sample <= v + {14'h0, 2'($random(seed))};
         ps_sample <= v + {14'h0, 2'($random(seed))};
      end
      @(posedge pclk);
      als_valid <= 1'h0;
      ps_valid <= 1'h0;
      repeat (2) @(posedge pclk);
      #1;
   endtask
   task automatic tick_gap(output int c);
      int n;
      n = 0;
      while (vis_adc_tick !== 1'h1 && n < 300) begin
         @(posedge pclk);
         #1;
         n++;
      end
      c = 0;
      do begin
         @(posedge pclk);
         #1;
         c++;
      end while (vis_adc_tick !== 1'h1 && c < 300);
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      seed = 18;
      err_count = 0;
      n_compared = 0;
      presetn = 1'h0;
      als_valid = 1'h0;
      ps_valid = 1'h0;
      ps_channel = 2'h0;
      als_sample = 16'h0;
      ps_sample = 16'h0;
      repeat (5) @(posedge pclk);
      #1;
      chk({irq, als_low_status, als_high_status, ps_status, visible_gain_exponent}, 33'h0);
      @(posedge pclk);
      presetn <= 1'h1;
      rd(lsgtf_pkg::IDX_VIS_GAIN, 32'h0);
      rd(lsgtf_pkg::IDX_VIS_MISC, 32'h0);
      rd(lsgtf_pkg::IDX_AMB_HYST, 32'h48);
      rd(lsgtf_pkg::IDX_PRX_HYST, 32'h48);
      rd(lsgtf_pkg::IDX_PS_PERSIST, 32'h03);
      rd(lsgtf_pkg::IDX_ALS_PERSIST, 32'h03);
      bus(12'hc00, 1'h0, 32'h0, 33'h1_0000_0000);
      for (int g = 0; g < 8; g++) begin
         wr(lsgtf_pkg::IDX_VIS_GAIN, 32'(g));
         chk(visible_gain_exponent, 33'(g));
         chk(33'(host.recovery_for(visible_gain_exponent)), 33'(3'h7 - 3'(g)));
         tick_gap(gap);
         chk(33'(gap), 33'h1 << g);
      end
      wr(lsgtf_pkg::IDX_VIS_MISC, 32'h20);
      rd(lsgtf_pkg::IDX_VIS_MISC, 32'h20);
      chk(visible_signal_range, 33'h1);
      wr(lsgtf_pkg::IDX_IR_CFG, 32'h02);
      chk({ir_signal_range, ir_gain_exponent}, 33'h2);
      wr(lsgtf_pkg::IDX_SEQ_CFG, 32'h01);
      chk({ir_signal_range, ir_gain_exponent}, 33'hf);
      // ambient high: threshold 1000, hysteresis 24, run of three
      wr(lsgtf_pkg::IDX_AMB_HIGH_TH, 32'h03e8);
      wr(lsgtf_pkg::IDX_ALS_PERSIST, 32'h07);
      smp(1'h0, 2'h0, 16'h0401, 2);
      smp(1'h0, 2'h0, 16'h03e8, 1);
      smp(1'h0, 2'h0, 16'h0401, 2);
      chk(als_high_status, 33'h0);
      smp(1'h0, 2'h0, 16'h0401, 1);
      chk(als_high_status, 33'h1);
      chk(irq, 33'h0);
      rd(lsgtf_pkg::IDX_IRQ_STATUS, 32'h02);
      wr(lsgtf_pkg::IDX_IRQ_MASK, 32'h02);
      chk(irq, 33'h1);
      wr(lsgtf_pkg::IDX_IRQ_STATUS, 32'h02);
      chk(irq, 33'h0);
      wr(lsgtf_pkg::IDX_IRQ_MASK, 32'h00);
      smp(1'h0, 2'h0, 16'h03d4, 3);
      chk(als_high_status, 33'h1);
      smp(1'h0, 2'h0, 16'h03cc, 3);
      chk(als_high_status, 33'h0);
      // wider hysteresis code 0x58 stands for 48
      wr(lsgtf_pkg::IDX_AMB_HYST, 32'h58);
      smp(1'h0, 2'h0, 16'h0406, 3);
      chk(als_high_status, 33'h0);
      smp(1'h0, 2'h0, 16'h041a, 3);
      chk(als_high_status, 33'h1);
      wr(lsgtf_pkg::IDX_AMB_HYST, 32'h48);
      wr(lsgtf_pkg::IDX_AMB_LOW_TH, 32'h01f4);
      smp(1'h0, 2'h0, 16'h01e0, 3);
      chk(als_low_status, 33'h0);
      smp(1'h0, 2'h0, 16'h01d8, 3);
      chk(als_low_status, 33'h1);
      // proximity: threshold 2000 on each channel, hysteresis 48, run of eight
      wr(lsgtf_pkg::IDX_PRX_HYST, 32'h58);
      wr(lsgtf_pkg::IDX_PS_PERSIST, 32'hff);
      for (int ch = 0; ch < 3; ch++) begin
         wr(lsgtf_pkg::IDX_PS_TH0 + 8'(ch), 32'h07d0);
         smp(1'h1, 2'(ch), 16'h07ee, 8);
         chk(ps_status[ch], 33'h0);
         smp(1'h1, 2'(ch), 16'h0802, 7);
         chk(ps_status[ch], 33'h0);
         smp(1'h1, 2'(ch), 16'h0802, 1);
         chk(ps_status[ch], 33'h1);
      end
      repeat (4) @(posedge pclk);
      stop_test();
   end
endmodule
